//--- crc_consts.vh
`ifndef CRC_CONSTS_VH
`define CRC_CONSTS_VH
// special function register addresses
`define CRC_CONTROL_ADDR      8'h91
`define CRC_INPUT_ADDR        8'h94
`define CRC_RESULT_DATA_ADDR  8'hd9
// control register field positions
`define CTL_PTR_LSB           0
`define CTL_PTR_MSB           1
`define CTL_INIT_VAL_BIT      2
`define CTL_INIT_STROBE_BIT   3
`define CTL_POLY_SEL_BIT      4
// reset values
`define CTL_RESET             8'h00
`define RESULT_RESET          32'h00000000
// polynomials and initial values
`define POLY16                16'h1021
`define POLY32                32'h04c11db7
`define POLY32_REFLECTED      32'hedb88320
`define INIT_ZERO             32'h00000000
`define INIT_ONES             32'hffffffff
`endif

//--- crc_byte_engine.v
`timescale 1ns/1ns
`include "crc_consts.vh"
// folds one input byte into the running result in a single cycle
module crc_byte_engine (
  input  wire        width16_i,
  input  wire [31:0] result_i,
  input  wire [7:0]  byte_i,
  output reg  [31:0] result_o
);
  reg [15:0] acc16;
  reg [31:0] acc32;
  integer    i;

  // both engines unrolled over eight bit steps; the select picks one
  always @* begin
    acc16 = result_i[15:0] ^ {byte_i, 8'h00};
    acc32 = result_i ^ {24'h000000, byte_i};
    for (i = 0; i < 8; i = i + 1) begin
      if (acc16[15]) begin
        acc16 = {acc16[14:0], 1'b0} ^ `POLY16;
      end else begin
        acc16 = {acc16[14:0], 1'b0};
      end
      if (acc32[0]) begin
        acc32 = {1'b0, acc32[31:1]} ^ `POLY32_REFLECTED;
      end else begin
        acc32 = {1'b0, acc32[31:1]};
      end
    end
    // upper half kept at zero in 16-bit mode so the two widths never mix
    if (width16_i) begin
      result_o = {16'h0000, acc16};
    end else begin
      result_o = acc32;
    end
  end
endmodule

//--- crc_unit_control.v
`timescale 1ns/1ns
`include "crc_consts.vh"
module crc_unit_control (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [7:0]  sfr_addr_i,
  input  wire [7:0]  sfr_wdata_i,
  input  wire        sfr_wr_i,
  input  wire        sfr_rd_i,
  output reg  [7:0]  sfr_rdata_o,
  output reg         sfr_hit_o,
  output reg         poly_width_select_o,
  output reg         init_value_select_o,
  output reg  [1:0]  result_byte_pointer_o,
  output reg  [31:0] result_o
);
  reg  [1:0]  ptr_nxt;
  reg  [31:0] result_nxt;
  reg  [7:0]  rdata_nxt;
  reg  [1:0]  lane;
  wire [7:0]  ctl_reset;
  wire [31:0] folded;
  wire [31:0] init_value;
  wire [31:0] port_merged;
  wire [3:0]  lane_hit;
  wire [7:0]  lane_byte [0:3];
  wire        ctl_sel;
  wire        in_sel;
  wire        dat_sel;
  wire        ctl_wr;
  wire        ctl_rd;
  wire        in_wr;
  wire        dat_wr;
  wire        dat_rd;
  wire        dat_acc;
  wire        init_go;
  wire        hit;

  // reset image of the control register, so each field takes its own bits
  assign ctl_reset = `CTL_RESET;

  // address match of the three registers this block answers
  assign ctl_sel = (sfr_addr_i == `CRC_CONTROL_ADDR);
  assign in_sel  = (sfr_addr_i == `CRC_INPUT_ADDR);
  assign dat_sel = (sfr_addr_i == `CRC_RESULT_DATA_ADDR);

  // qualified strobes; the host never raises read and write together
  assign ctl_wr  = sfr_wr_i && ctl_sel;
  assign ctl_rd  = sfr_rd_i && ctl_sel;
  assign in_wr   = sfr_wr_i && in_sel;
  assign dat_wr  = sfr_wr_i && dat_sel;
  assign dat_rd  = sfr_rd_i && dat_sel;
  assign dat_acc = dat_wr || dat_rd;

  // any access to a mapped address; unmapped ones are left unanswered
  assign hit = (sfr_wr_i || sfr_rd_i) && (ctl_sel || in_sel || dat_sel);

  // the initialise bit is only a strobe: it acts on the write and is not kept
  assign init_go = ctl_wr && sfr_wdata_i[`CTL_INIT_STROBE_BIT];

  // initial value comes from the select bit being written in the same cycle,
  // so one write can choose the value and load it at once
  assign init_value = sfr_wdata_i[`CTL_INIT_VAL_BIT] ? `INIT_ONES : `INIT_ZERO;

  // the byte engine folds the write data against the current result;
  // it is purely combinational, so a fold takes exactly one bus cycle
  crc_byte_engine crc_byte_engine_i (
    .width16_i (poly_width_select_o),
    .result_i  (result_o),
    .byte_i    (sfr_wdata_i),
    .result_o  (folded)
  );

  // lane chosen by the pointer; 16-bit mode folds the pointer onto two bytes
  always @* begin
    if (poly_width_select_o) begin
      lane = {1'b0, result_byte_pointer_o[0]};
    end else begin
      lane = result_byte_pointer_o;
    end
  end

  // one-hot lane decode used by the write merge; the read mux indexes lane_byte by lane
  assign lane_hit = 4'h1 << lane;

  // per byte lane: read view of the result and the merged write value;
  // only the pointed lane takes the port data, the others keep their bits
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_lane
      assign lane_byte[k] = result_o[8*k +: 8];
      assign port_merged[8*k +: 8] = (dat_wr && lane_hit[k]) ? sfr_wdata_i
                                                               : result_o[8*k +: 8];
    end
  endgenerate

  // pointer: a control write sets it, a data port access advances it;
  // the pointer always counts over four values, the lane map does the wrap
  always @* begin
    ptr_nxt = result_byte_pointer_o;
    if (ctl_wr) begin
      ptr_nxt = sfr_wdata_i[`CTL_PTR_MSB:`CTL_PTR_LSB];
    end else if (dat_acc) begin
      ptr_nxt = result_byte_pointer_o + 2'h1;
    end
  end

  // result: init wins over data, since both cannot come in one bus cycle;
  // init loads all 32 bits even in 16-bit mode so a later switch sees it
  always @* begin
    result_nxt = result_o;
    if (init_go) begin
      result_nxt = init_value;
    end else if (in_wr) begin
      result_nxt = folded;
    end else if (dat_wr) begin
      result_nxt = port_merged;
    end
  end

  // read mux; the strobe bit and bits 7 to 5 always read as zero.
  // idle cycles return zero so a stale byte never lingers on the bus
  always @* begin
    rdata_nxt = 8'h00;
    if (ctl_rd) begin
      rdata_nxt = {3'h0, poly_width_select_o, 1'b0, init_value_select_o,
                   result_byte_pointer_o};
    end else if (dat_rd) begin
      rdata_nxt = lane_byte[lane];
    end
  end

  // polynomial and result width select; bits 7 to 5 have no storage at all
  always @(posedge clk_i) begin
    if (rst_i) begin
      poly_width_select_o <= ctl_reset[`CTL_POLY_SEL_BIT];
    end else if (ctl_wr) begin
      poly_width_select_o <= sfr_wdata_i[`CTL_POLY_SEL_BIT];
    end
  end

  // initial-value select, kept for readback; the load itself uses write data
  always @(posedge clk_i) begin
    if (rst_i) begin
      init_value_select_o <= ctl_reset[`CTL_INIT_VAL_BIT];
    end else if (ctl_wr) begin
      init_value_select_o <= sfr_wdata_i[`CTL_INIT_VAL_BIT];
    end
  end

  // result byte pointer
  always @(posedge clk_i) begin
    if (rst_i) begin
      result_byte_pointer_o <= ctl_reset[`CTL_PTR_MSB:`CTL_PTR_LSB];
    end else begin
      result_byte_pointer_o <= ptr_nxt;
    end
  end

  // internal result register
  always @(posedge clk_i) begin
    if (rst_i) begin
      result_o <= `RESULT_RESET;
    end else begin
      result_o <= result_nxt;
    end
  end

  // read data and hit are registered: both stand for the cycle after access;
  // costs a cycle of latency but keeps every output straight from a flop
  always @(posedge clk_i) begin
    if (rst_i) begin
      sfr_rdata_o <= 8'h00;
      sfr_hit_o   <= 1'b0;
    end else begin
      sfr_rdata_o <= rdata_nxt;
      sfr_hit_o   <= hit;
    end
  end
endmodule

//--- crc_unit_control_assertions.sv
`timescale 1ns/1ns
`include "crc_consts.vh"
module crc_unit_control_assertions (
  input wire        clk_i,
  input wire        rst_i,
  input wire [7:0]  sfr_addr_i,
  input wire [7:0]  sfr_wdata_i,
  input wire        sfr_wr_i,
  input wire        sfr_rd_i,
  input wire [7:0]  sfr_rdata_o,
  input wire        sfr_hit_o,
  input wire        poly_width_select_o,
  input wire        init_value_select_o,
  input wire [1:0]  result_byte_pointer_o,
  input wire [31:0] result_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // decode and the byte the data port reaches; 16-bit mode wraps on two bytes
  wire       ctl  = sfr_addr_i == `CRC_CONTROL_ADDR;
  wire       dat  = sfr_addr_i == `CRC_RESULT_DATA_ADDR;
  wire       map  = ctl | dat | (sfr_addr_i == `CRC_INPUT_ADDR);
  wire       acc  = sfr_wr_i | sfr_rd_i;
  wire [1:0] bsel = poly_width_select_o ? {1'b0, result_byte_pointer_o[0]} : result_byte_pointer_o;
  wire [7:0] cur  = result_o[{bsel, 3'b000} +: 8];
  hit_map_a: assert property (acc |=> sfr_hit_o == $past(map)) else $error("hit flag wrong");
  unmapped_rd_a: assert property (sfr_rd_i && !map |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  ctl_read_a: assert property (sfr_rd_i && ctl |=> sfr_rdata_o == {3'h0,
    poly_width_select_o, 1'b0, init_value_select_o, result_byte_pointer_o})
    else $error("control readback wrong");
  ctl_write_a: assert property (sfr_wr_i && ctl |=> {poly_width_select_o,
    init_value_select_o, result_byte_pointer_o} == $past({sfr_wdata_i[4], sfr_wdata_i[2:0]}))
    else $error("control fields not taken");
  init_load_a: assert property (sfr_wr_i && ctl && sfr_wdata_i[3] |=>
    result_o == ($past(sfr_wdata_i[2]) ? `INIT_ONES : `INIT_ZERO)) else $error("init value wrong");
  ptr_step_a: assert property (acc && dat |=>
    result_byte_pointer_o == $past(result_byte_pointer_o) + 2'h1) else $error("pointer step wrong");
  port_read_a: assert property (sfr_rd_i && dat |=> sfr_rdata_o == $past(cur))
    else $error("data port read wrong byte");
  port_write_a: assert property (sfr_wr_i && dat |=>
    result_o[{$past(bsel), 3'b000} +: 8] == $past(sfr_wdata_i)) else $error("data port write lost");
  cover property (sfr_wr_i && sfr_addr_i == `CRC_INPUT_ADDR && poly_width_select_o);
  cover property (sfr_rd_i && dat && result_byte_pointer_o == 2'h3);
  cover property (sfr_wr_i && ctl && sfr_wdata_i[3]);
endmodule
bind crc_unit_control crc_unit_control_assertions crc_unit_control_assertions_i (.clk_i, .rst_i,
  .sfr_addr_i, .sfr_wdata_i, .sfr_wr_i, .sfr_rd_i, .sfr_rdata_o, .sfr_hit_o,
  .poly_width_select_o, .init_value_select_o, .result_byte_pointer_o, .result_o);

//--- sfr_host.sv
`timescale 1ns/1ns
// host core: one-cycle strobes; idle lines go inverse so stale values never match
module sfr_host (
  input  wire       clk_i,
  input  wire [7:0] sfr_rdata_i,
  output reg  [7:0] sfr_addr_o  = 8'h00,
  output reg  [7:0] sfr_wdata_o = 8'h00,
  output reg        sfr_wr_o    = 1'b0,
  output reg        sfr_rd_o    = 1'b0
);
  task acc(input w, input [7:0] a, input [7:0] d, output [7:0] q);
    begin
      @(posedge clk_i);
      sfr_addr_o <= a;
      sfr_wdata_o <= d;
      sfr_wr_o <= w;
      sfr_rd_o <= !w;
      @(posedge clk_i);
      sfr_addr_o <= ~a;
      sfr_wdata_o <= ~d;
      {sfr_wr_o, sfr_rd_o} <= 2'b00;
      #1 q = sfr_rdata_i;
    end
  endtask
endmodule

//--- crc_unit_control_tb.sv
`timescale 1ns/1ns
`include "crc_consts.vh"
module crc_unit_control_tb;
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  wire [7:0]  addr, wdata, rdata;
  wire        wr, rd, hit, psel, vsel;
  wire [1:0]  ptr;
  wire [31:0] res;
  reg  [7:0]  r;
  integer     error_cnt = 0, checks = 0, i;
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  sfr_host sfr_host_i (.clk_i(clk_i), .sfr_rdata_i(rdata), .sfr_addr_o(addr),
    .sfr_wdata_o(wdata), .sfr_wr_o(wr), .sfr_rd_o(rd));
  crc_unit_control crc_unit_control_i (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(addr),
    .sfr_wdata_i(wdata), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdata), .sfr_hit_o(hit),
    .poly_width_select_o(psel), .init_value_select_o(vsel),
    .result_byte_pointer_o(ptr), .result_o(res));
  task chk(input [47:0] g, input [47:0] e);
    begin
      checks = checks + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  task w(input [7:0] a, input [7:0] v);
    sfr_host_i.acc(1'b1, a, v, r);
  endtask
  task rdb(input [7:0] a);
    sfr_host_i.acc(1'b0, a, 8'h00, r);
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // reserved bits and the init strobe must read back zero
  task t_ctl;
    begin
      rdb(`CRC_CONTROL_ADDR);
      chk({hit, res, r}, {1'b1, `RESULT_RESET, `CTL_RESET});
      w(`CRC_CONTROL_ADDR, 8'hff);
      chk({psel, vsel, ptr}, 4'hf);
      rdb(`CRC_CONTROL_ADDR);
      chk({res, r}, {`INIT_ONES, 8'h17});
      w(`CRC_CONTROL_ADDR, 8'h08);
      chk(res, `INIT_ZERO);
      $display("control test done");
    end
  endtask
  // 32-bit: three bytes, then all four result bytes through the port
  task t_crc32;
    begin
      w(`CRC_CONTROL_ADDR, 8'h0c);
      for (i = 0; i < 3; i = i + 1) w(`CRC_INPUT_ADDR, 8'haa + 8'h11 * i);
      chk(res, 32'h41b207b3);
      for (i = 0; i < 4; i = i + 1) begin
        rdb(`CRC_RESULT_DATA_ADDR);
        chk(r, (32'h41b207b3 >> (8 * i)) & 32'hff);
      end
      chk(ptr, 2'b00);
      $display("crc32 test done");
    end
  endtask
  // 16-bit: port reads and writes wrap over two bytes while the pointer counts over four
  task t_crc16;
    begin
      w(`CRC_CONTROL_ADDR, 8'h1c);
      w(`CRC_INPUT_ADDR, 8'h63);
      chk(res, 32'h0000bd35);
      for (i = 0; i < 4; i = i + 1) begin
        rdb(`CRC_RESULT_DATA_ADDR);
        chk(r, i[0] ? 8'hbd : 8'h35);
      end
      w(`CRC_RESULT_DATA_ADDR, 8'h11);
      w(`CRC_RESULT_DATA_ADDR, 8'h22);
      w(`CRC_RESULT_DATA_ADDR, 8'h33);
      chk(res, 32'h00002233);
      $display("crc16 test done");
    end
  endtask
  // port writes land on the pointed byte; unmapped reads give nothing
  task t_port;
    begin
      w(`CRC_CONTROL_ADDR, 8'h00);
      w(`CRC_RESULT_DATA_ADDR, 8'h5a);
      w(`CRC_RESULT_DATA_ADDR, 8'ha5);
      chk({ptr, res[15:0]}, {2'h2, 16'ha55a});
      rdb(8'h92);
      chk({hit, r}, 9'h000);
      $display("port test done");
    end
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_ctl;
    t_crc32;
    t_crc16;
    t_port;
    final_report;
  end
  // whole run is 25 accesses of two cycles each
  initial begin
    #20000;
    error_cnt = error_cnt + 1;
    final_report;
  end
endmodule
